// *** cpu_port_model.sv ***
/*
 CPU side of the timer's 8-bit I/O port: byte and word accesses.
 Assumes the bench clock; requests launch on falling edges.
*/
`timescale 1ns/1ns
module cpu_port_model
   import timer16_pkg::*;
(
   input  wire logic       clk_sys,
   output io_req_s         ioReq,
   input  wire logic [7:0] ioRdata
);
   // Port idle until a task makes a request
   initial begin
      ioReq = '0;
   end

   // One write strobe, then released with inverted lines
   task automatic wr8(input logic [5:0] addr, input logic [7:0] data);
      @(negedge clk_sys);
      ioReq = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
      @(negedge clk_sys);
      ioReq = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
   endtask

   // One read strobe; data is taken once the answer edge has passed
   task automatic rd8(input logic [5:0] addr, output logic [7:0] data);
      @(negedge clk_sys);
      ioReq = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
      @(negedge clk_sys);
      ioReq = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'hFF};
      data = ioRdata;
   endtask

   // High byte first, nothing between the two bytes
   task automatic wr16(input logic [5:0] lowAddr, input logic [15:0] val);
      wr8(lowAddr + 6'h01, val[15:8]);
      wr8(lowAddr, val[7:0]);
   endtask

   // Low byte first, nothing between the two bytes
   task automatic rd16(input logic [5:0] lowAddr, output logic [15:0] val);
      rd8(lowAddr, val[7:0]);
      rd8(lowAddr + 6'h01, val[15:8]);
   endtask
endmodule

// *** timer16_counter_capture.sv ***
/*
 16-bit timer/counter with input capture behind an 8-bit CPU I/O port.
 Assumes pins and comparator output are asynchronous, CPU strobes are
 synchronous to clk_sys and software orders its byte accesses itself.
*/
`timescale 1ns/1ns
module timer16_counter_capture
   import timer16_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  io_req_s         ioReq,
   output logic [7:0]      ioRdata,
   input  wire logic       captureInPin,
   input  wire logic       comparatorOutput,
   input  wire logic       captureSourceSel,
   input  wire logic       extClockPin,
   input  wire logic       ovfIrqAck,
   input  wire logic       capIrqAck,
   output logic            ovfIrq,
   output logic            capIrq
);

   logic [7:0]  ctrlA_q;
   logic [7:0]  ctrlB_q;
   logic [7:0]  mask_q;
   logic [7:0]  temp_q;
   logic [7:0]  rdata_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] icr_q;
   logic [15:0] topValue;
   logic [9:0]  presc_q;
   logic        down_q;
   logic        down_d;
   logic        ovfFlag_q;
   logic        capFlag_q;
   logic        extSync1_q;
   logic        extSync2_q;
   logic        extLast_q;
   logic        pinSync1_q;
   logic        pinSync2_q;
   logic        cmpSync1_q;
   logic        cmpSync2_q;
   logic        capLast_q;
   logic        tick;
   logic [7:0]  readMux;

   // Port decode
   wire         wrCntL   = ioReq.wr && (ioReq.addr == ADDR_CNT_L);
   wire         wrCapL   = ioReq.wr && (ioReq.addr == ADDR_CAP_L);
   wire         wrHigh   = ioReq.wr && ((ioReq.addr == ADDR_CNT_H) ||
                                        (ioReq.addr == ADDR_CAP_H));
   wire         wrCtrlA  = ioReq.wr && (ioReq.addr == ADDR_CTRL_A);
   wire         wrCtrlB  = ioReq.wr && (ioReq.addr == ADDR_CTRL_B);
   wire         wrFlags  = ioReq.wr && (ioReq.addr == ADDR_FLAGS);
   wire         wrMask   = ioReq.wr && (ioReq.addr == ADDR_MASK);
   wire         rdCntL   = ioReq.rd && (ioReq.addr == ADDR_CNT_L);
   wire         rdCapL   = ioReq.rd && (ioReq.addr == ADDR_CAP_L);

   // Mode decode from bits split over both control registers
   wire [3:0]   waveMode  = {ctrlB_q[CTRLB_WGM_LO+1:CTRLB_WGM_LO], ctrlA_q[1:0]};
   wire [2:0]   clockSel  = ctrlB_q[2:0];
   wire         icrTop    = ICR_TOP_MODES[waveMode];
   wire         dualSlope = DUAL_MODES[waveMode];
   wire         ctcMode   = CTC_MODES[waveMode];

   // Top of the count sequence
   always_comb begin
      if (icrTop) begin
         topValue = icr_q;
      end else if (TOP8_MODES[waveMode]) begin
         topValue = TOP_8;
      end else if (TOP9_MODES[waveMode]) begin
         topValue = TOP_9;
      end else if (TOP10_MODES[waveMode]) begin
         topValue = TOP_10;
      end else begin
         topValue = CNT_MAX;
      end
   end

   // Counter datapath controls and indications
   wire         atTop     = (cnt_q == topValue);
   wire         atZero    = (cnt_q == CNT_ZERO);
   wire         countEn   = tick;
   wire         clearCnt  = !dualSlope && atTop;
   wire         countDown = dualSlope && (atTop || (down_q && !atZero));
   wire         ovfPoint  = dualSlope ? (atZero && down_q)
                                      : (atTop && (!ctcMode || cnt_q == CNT_MAX));
   wire         ovfSet    = countEn && !wrCntL && ovfPoint;

   // External clock pin synchroniser and edge detect
   wire         extRise   = extSync2_q && !extLast_q;
   wire         extFall   = !extSync2_q && extLast_q;

   // Timer tick from prescaler tap or external edge
   always_comb begin
      case (clockSel)
         CS_STOP:     tick = 1'b0;
         CS_DIV1:     tick = 1'b1;
         CS_DIV8:     tick = (presc_q & PRE_MASK_8) == PRE_MASK_8;
         CS_DIV64:    tick = (presc_q & PRE_MASK_64) == PRE_MASK_64;
         CS_DIV256:   tick = (presc_q & PRE_MASK_256) == PRE_MASK_256;
         CS_DIV1024:  tick = (presc_q & PRE_MASK_1024) == PRE_MASK_1024;
         CS_EXT_FALL: tick = extFall;
         CS_EXT_RISE: tick = extRise;
         default:     tick = 1'b0;
      endcase
   end

   // Capture source select and edge qualification
   wire         capSel   = captureSourceSel ? cmpSync2_q : pinSync2_q;
   wire         edgeRise = ctrlB_q[CTRLB_EDGE];
   wire         capTrig  = !icrTop && (capSel != capLast_q) && (capSel == edgeRise);

   // Next counter value: CPU write first, then clear or step
   always_comb begin
      cnt_d  = cnt_q;
      down_d = down_q;
      if (wrCntL) begin
         cnt_d = {temp_q, ioReq.wdata};
      end else if (countEn) begin
         down_d = countDown;
         if (clearCnt) begin
            cnt_d = CNT_ZERO;
         end else if (countDown) begin
            cnt_d = cnt_q - 16'h0001;
         end else begin
            cnt_d = cnt_q + 16'h0001;
         end
      end
   end

   // Read data selection; high locations return the holding register
   always_comb begin
      readMux = BYTE_RST;
      case (ioReq.addr)
         ADDR_CTRL_A: readMux = ctrlA_q;
         ADDR_CTRL_B: readMux = ctrlB_q;
         ADDR_CNT_L:  readMux = cnt_q[7:0];
         ADDR_CNT_H:  readMux = temp_q;
         ADDR_CAP_L:  readMux = icr_q[7:0];
         ADDR_CAP_H:  readMux = temp_q;
         ADDR_FLAGS: begin
            readMux[FLAG_OVF] = ovfFlag_q;
            readMux[FLAG_CAP] = capFlag_q;
         end
         ADDR_MASK:   readMux = mask_q;
         default:     readMux = BYTE_RST;
      endcase
   end

   // Pin synchronisers and edge history
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         extSync1_q <= 1'b0;
         extSync2_q <= 1'b0;
         extLast_q  <= 1'b0;
         pinSync1_q <= 1'b0;
         pinSync2_q <= 1'b0;
         cmpSync1_q <= 1'b0;
         cmpSync2_q <= 1'b0;
         capLast_q  <= 1'b0;
      end else begin
         extSync1_q <= extClockPin;
         extSync2_q <= extSync1_q;
         extLast_q  <= extSync2_q;
         pinSync1_q <= captureInPin;
         pinSync2_q <= pinSync1_q;
         cmpSync1_q <= comparatorOutput;
         cmpSync2_q <= cmpSync1_q;
         capLast_q  <= capSel;
      end
   end

   // Prescaler runs only while a clock source is selected
   always_ff @(posedge clk_sys) begin
      if (sys_rst || clockSel == CS_STOP) begin
         presc_q <= PRE_RST;
      end else begin
         presc_q <= presc_q + 10'h001;
      end
   end

   // Control registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrlA_q <= BYTE_RST;
         ctrlB_q <= BYTE_RST;
         mask_q  <= BYTE_RST;
      end else begin
         if (wrCtrlA) ctrlA_q <= ioReq.wdata;
         if (wrCtrlB) ctrlB_q <= ioReq.wdata;
         if (wrMask)  mask_q  <= ioReq.wdata;
      end
   end

   // Counter and direction
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_q  <= CNT_RST;
         down_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         down_q <= down_d;
      end
   end

   // Shared holding register for every upper byte
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         temp_q <= BYTE_RST;
      end else if (wrHigh) begin
         temp_q <= ioReq.wdata;
      end else if (rdCntL) begin
         temp_q <= cnt_q[15:8];
      end else if (rdCapL) begin
         temp_q <= icr_q[15:8];
      end
   end

   // Capture register: CPU write only in capture-top modes
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         icr_q <= CNT_RST;
      end else if (wrCapL && icrTop) begin
         icr_q <= {temp_q, ioReq.wdata};
      end else if (capTrig) begin
         icr_q <= cnt_q;
      end
   end

   // Flags: a set in the same cycle as a clear wins
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ovfFlag_q <= 1'b0;
         capFlag_q <= 1'b0;
      end else begin
         ovfFlag_q <= ovfSet || (ovfFlag_q &&
                      !(ovfIrqAck || (wrFlags && ioReq.wdata[FLAG_OVF])));
         capFlag_q <= capTrig || (capFlag_q &&
                      !(capIrqAck || (wrFlags && ioReq.wdata[FLAG_CAP])));
      end
   end

   // Registered read data
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_q <= BYTE_RST;
      end else if (ioReq.rd) begin
         rdata_q <= readMux;
      end
   end

   // Outputs
   assign ioRdata = rdata_q;
   assign ovfIrq  = ovfFlag_q && mask_q[FLAG_OVF];
   assign capIrq  = capFlag_q && mask_q[FLAG_CAP];

   // Checks
   cntWrite_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wrCntL |=> cnt_q == {$past(temp_q), $past(ioReq.wdata)})
      else $error("counter write lost or mixed with count");
   stopHold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clockSel == CS_STOP && !wrCntL) |=> $stable(cnt_q))
      else $error("stopped counter changed");
   lowReadTemp_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (rdCntL && !wrHigh) |=> temp_q == $past(cnt_q[15:8]))
      else $error("counter low read did not load holding byte");
   normalStep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (waveMode == 4'h0 && tick && !wrCntL && cnt_q != CNT_MAX)
      |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("normal mode did not increment");
   ovfSet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (waveMode == 4'h0 && tick && !wrCntL && cnt_q == CNT_MAX)
      |=> ovfFlag_q && cnt_q == CNT_ZERO)
      else $error("overflow not flagged at wrap");
   topClear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!dualSlope && tick && !wrCntL && atTop) |=> cnt_q == CNT_ZERO)
      else $error("single slope count not cleared at top");
   dualTurn_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (dualSlope && tick && !wrCntL && atTop) |=> cnt_q == $past(cnt_q) - 16'h0001)
      else $error("dual slope count did not turn down at top");
   capCopy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      capTrig |=> (icr_q == $past(cnt_q)) && capFlag_q)
      else $error("capture copy or flag missing");
   capIrq_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (capTrig && mask_q[FLAG_CAP] && !wrMask) |=> capIrq)
      else $error("capture interrupt not raised");
   capClear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (capIrqAck && !capTrig) |=> !capFlag_q)
      else $error("capture flag not cleared on service");
   capWrIgnore_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (wrCapL && !icrTop && !capTrig) |=> $stable(icr_q))
      else $error("capture write accepted in wrong mode");
   tempKeep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (wrCntL || wrCapL) |=> $stable(temp_q))
      else $error("holding byte changed by low write");
   highRead_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (ioReq.rd && ioReq.addr == ADDR_CAP_H) |=> ioRdata == $past(temp_q))
      else $error("capture high read not from holding byte");

endmodule

// *** timer16_counter_capture_tb.sv ***
/*
 Self-checking bench of the 16-bit timer with input capture.
 Assumes cpu_port_model drives the I/O port; pins are driven here.
*/
`timescale 1ns/1ns
module timer16_counter_capture_tb
   import timer16_pkg::*;
;
   typedef struct packed {
      logic [5:0]  lowAddr;
      logic [15:0] wval;
      logic [15:0] exp;
   } row_s;

   logic        clk_sys;
   logic        sys_rst;
   io_req_s     ioReq;
   logic [7:0]  ioRdata;
   logic        captureInPin;
   logic        comparatorOutput;
   logic        captureSourceSel;
   logic        extClockPin;
   logic        ovfIrqAck;
   logic        capIrqAck;
   logic        ovfIrq;
   logic        capIrq;
   int          failures;
   int          compares;
   int          cycles;
   logic [15:0] w;
   logic [7:0]  b;
   row_s        rows [4] = '{'{ADDR_CNT_L, 16'h01FF, 16'h01FF},
                             '{ADDR_CNT_L, 16'hFFFF, 16'hFFFF},
                             '{ADDR_CNT_L, 16'h0000, 16'h0000},
                             '{ADDR_CAP_L, 16'h1234, 16'h0000}};

   timer16_counter_capture timer16_counter_capture_i (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .ioReq(ioReq), .ioRdata(ioRdata),
      .captureInPin(captureInPin), .comparatorOutput(comparatorOutput),
      .captureSourceSel(captureSourceSel), .extClockPin(extClockPin),
      .ovfIrqAck(ovfIrqAck), .capIrqAck(capIrqAck), .ovfIrq(ovfIrq), .capIrq(capIrq));

   cpu_port_model cpu_port_model_i (.clk_sys(clk_sys), .ioReq(ioReq), .ioRdata(ioRdata));

   // 50 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {captureInPin, comparatorOutput, captureSourceSel, extClockPin} = 4'h0;
      {ovfIrqAck, capIrqAck} = 2'h0;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys) sys_rst = 1'b0;
      cpu_port_model_i.rd16(ADDR_CNT_L, w);
      chk("count at reset", 16'h0000, w);
      cpu_port_model_i.rd16(ADDR_CAP_L, w);
      chk("capture at reset", 16'h0000, w);
      cpu_port_model_i.rd8(ADDR_FLAGS, b);
      chk("flags at reset", 16'h0000, {8'h00, b});
      $display("test reset done");
      // Stopped timer: words written and read back
      foreach (rows[i]) begin
         cpu_port_model_i.wr16(rows[i].lowAddr, rows[i].wval);
         idle(8);
         cpu_port_model_i.rd16(rows[i].lowAddr, w);
         chk("row readback", rows[i].exp, w);
      end
      $display("test table done");
      // Capture register writable in a capture-top mode
      cpu_port_model_i.wr8(ADDR_CTRL_B, 8'h18);
      cpu_port_model_i.wr16(ADDR_CAP_L, 16'hBEEF);
      cpu_port_model_i.rd16(ADDR_CAP_L, w);
      chk("capture write", 16'hBEEF, w);
      cpu_port_model_i.wr8(ADDR_CTRL_B, 8'h00);
      cpu_port_model_i.rd8(ADDR_CAP_L, b);
      cpu_port_model_i.rd8(ADDR_CNT_H, b);
      chk("shared hold", 16'h00BE, {8'h00, b});
      cpu_port_model_i.wr8(ADDR_CNT_H, 8'h12);
      cpu_port_model_i.wr8(ADDR_CNT_L, 8'h34);
      cpu_port_model_i.wr8(ADDR_CNT_L, 8'h56);
      cpu_port_model_i.rd16(ADDR_CNT_L, w);
      chk("hold kept", 16'h1256, w);
      $display("test holding done");
      // External rising ticks
      cpu_port_model_i.wr16(ADDR_CNT_L, 16'h0000);
      cpu_port_model_i.wr8(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
      repeat (3) begin
         @(negedge clk_sys) extClockPin = 1'b1;
         idle(6);
         @(negedge clk_sys) extClockPin = 1'b0;
         idle(6);
      end
      cpu_port_model_i.wr8(ADDR_CTRL_B, 8'h00);
      cpu_port_model_i.rd16(ADDR_CNT_L, w);
      chk("external count", 16'h0003, w);
      // Overflow in normal mode
      cpu_port_model_i.wr16(ADDR_CNT_L, 16'hFFFE);
      cpu_port_model_i.wr8(ADDR_MASK, 8'h21);
      cpu_port_model_i.wr8(ADDR_CTRL_B, {5'h00, CS_DIV1});
      idle(6);
      chk("overflow irq", 16'h0001, {15'h0, ovfIrq});
      cpu_port_model_i.wr8(ADDR_CTRL_B, 8'h00);
      cpu_port_model_i.rd8(ADDR_FLAGS, b);
      chk("overflow flag", 16'h0001, {15'h0, b[FLAG_OVF]});
      @(negedge clk_sys) ovfIrqAck = 1'b1;
      @(negedge clk_sys) ovfIrqAck = 1'b0;
      chk("overflow serviced", 16'h0000, {15'h0, ovfIrq});
      // Mode 1 from control A bits: dual slope turns down at 0x00FF, six ticks
      cpu_port_model_i.wr8(ADDR_CTRL_A, 8'h01);
      cpu_port_model_i.wr16(ADDR_CNT_L, 16'h00FD);
      cpu_port_model_i.wr8(ADDR_CTRL_B, {5'h00, CS_DIV1});
      idle(4);
      cpu_port_model_i.wr8(ADDR_CTRL_B, 8'h00);
      cpu_port_model_i.rd16(ADDR_CNT_L, w);
      chk("dual slope count", 16'h00FB, w);
      // Mode 5 from both registers: single slope clears at 0x00FF, six ticks
      cpu_port_model_i.wr16(ADDR_CNT_L, 16'h00FD);
      cpu_port_model_i.wr8(ADDR_CTRL_B, {5'h01, CS_DIV1});
      idle(4);
      cpu_port_model_i.wr8(ADDR_CTRL_B, 8'h00);
      cpu_port_model_i.rd16(ADDR_CNT_L, w);
      chk("single slope count", 16'h0003, w);
      cpu_port_model_i.rd8(ADDR_FLAGS, b);
      chk("top overflow flag", 16'h0001, {15'h0, b[FLAG_OVF]});
      cpu_port_model_i.wr8(ADDR_FLAGS, 8'h01);
      chk("overflow write clear", 16'h0000, {15'h0, ovfIrq});
      cpu_port_model_i.wr8(ADDR_CTRL_A, 8'h00);
      // Divide by 8: ticks 8 and 16 clocks after enable, stopped at 22
      cpu_port_model_i.wr16(ADDR_CNT_L, 16'h0100);
      cpu_port_model_i.wr8(ADDR_CTRL_B, {5'h00, CS_DIV8});
      idle(20);
      cpu_port_model_i.wr8(ADDR_CTRL_B, 8'h00);
      cpu_port_model_i.rd16(ADDR_CNT_L, w);
      chk("divide by 8 count", 16'h0102, w);
      $display("test counting done");
      // Rising capture from the pin
      cpu_port_model_i.wr16(ADDR_CNT_L, 16'h4321);
      cpu_port_model_i.wr8(ADDR_CTRL_B, 8'h40);
      @(negedge clk_sys) captureInPin = 1'b1;
      idle(6);
      chk("capture irq", 16'h0001, {15'h0, capIrq});
      cpu_port_model_i.rd16(ADDR_CAP_L, w);
      chk("pin capture", 16'h4321, w);
      cpu_port_model_i.wr8(ADDR_FLAGS, 8'h20);
      chk("flag write clear", 16'h0000, {15'h0, capIrq});
      // Falling capture from the comparator; source switch may capture
      cpu_port_model_i.wr8(ADDR_CTRL_B, 8'h00);
      @(negedge clk_sys) comparatorOutput = 1'b1;
      idle(4);
      captureSourceSel = 1'b1;
      idle(6);
      cpu_port_model_i.wr8(ADDR_FLAGS, 8'h20);
      cpu_port_model_i.wr16(ADDR_CNT_L, 16'h5678);
      @(negedge clk_sys) comparatorOutput = 1'b0;
      idle(6);
      chk("comparator irq", 16'h0001, {15'h0, capIrq});
      cpu_port_model_i.rd16(ADDR_CAP_L, w);
      chk("comparator capture", 16'h5678, w);
      @(negedge clk_sys) capIrqAck = 1'b1;
      @(negedge clk_sys) capIrqAck = 1'b0;
      chk("capture serviced", 16'h0000, {15'h0, capIrq});
      $display("test capture done");
      // Second reset in mid-run, then an unmapped read
      @(negedge clk_sys) sys_rst = 1'b1;
      idle(4);
      sys_rst = 1'b0;
      cpu_port_model_i.rd16(ADDR_CNT_L, w);
      chk("count after reset", 16'h0000, w);
      cpu_port_model_i.rd16(ADDR_CAP_L, w);
      chk("capture after reset", 16'h0000, w);
      cpu_port_model_i.rd8(6'h3F, b);
      chk("unmapped read", 16'h0000, {8'h00, b});
      $display("test reset again done");
      close_out();
   end
endmodule

// *** timer16_pkg.sv ***
/*
 Constants and carrier types of the 16-bit timer/counter with input capture.
 Assumes an 8-bit CPU I/O port with single-cycle read and write strobes.
*/
// Operation
// - High byte goes through shared holding register
// - CPU counter write beats clear or count
// - Clock select zero stops the counter
// - Counter accessible whether ticking or not
// - Clear, increment or decrement per tick
// - Four waveform bits choose counting sequence
// - Overflow flag set per mode, raises interrupt
// - Count, direction, clear, top, zero controls
// - Clock select picks internal or external tick
// - Capture from pin or comparator output
// - Matching edge copies count into capture outside capture-top modes
// - Capture flag set with the copy
// - Enabled capture flag raises interrupt request
// - Flag cleared by service or writing one
// - Capture low read loads holding register
// - Capture writes only in capture-top modes
// - Holding register survives low-byte writes
// - One holding register for both 16-bit registers
// - Low write loads both bytes together
package timer16_pkg;

   // Register addresses on the I/O port
   localparam logic [5:0] ADDR_CTRL_A = 6'h00;
   localparam logic [5:0] ADDR_CTRL_B = 6'h01;
   localparam logic [5:0] ADDR_CNT_L  = 6'h04;
   localparam logic [5:0] ADDR_CNT_H  = 6'h05;
   localparam logic [5:0] ADDR_CAP_L  = 6'h06;
   localparam logic [5:0] ADDR_CAP_H  = 6'h07;
   localparam logic [5:0] ADDR_FLAGS  = 6'h08;
   localparam logic [5:0] ADDR_MASK   = 6'h09;

   // Field positions
   localparam int CTRLB_WGM_LO = 3;    // Waveform bits 3:2 sit at control B 4:3
   localparam int CTRLB_EDGE   = 6;    // Capture edge select, 1 = rising
   localparam int FLAG_OVF     = 0;
   localparam int FLAG_CAP     = 5;

   // Reset values
   localparam logic [7:0]  BYTE_RST = 8'h00;
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [9:0]  PRE_RST  = 10'h000;

   // Count values
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX  = 16'hFFFF;
   localparam logic [15:0] TOP_8    = 16'h00FF;
   localparam logic [15:0] TOP_9    = 16'h01FF;
   localparam logic [15:0] TOP_10   = 16'h03FF;

   // Waveform mode sets, one bit per mode number
   localparam logic [15:0] ICR_TOP_MODES = 16'h5500;
   localparam logic [15:0] DUAL_MODES    = 16'h0F0E;
   localparam logic [15:0] CTC_MODES     = 16'h1010;
   localparam logic [15:0] TOP8_MODES    = 16'h0022;
   localparam logic [15:0] TOP9_MODES    = 16'h0044;
   localparam logic [15:0] TOP10_MODES   = 16'h0088;

   // Clock select codes
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIV1     = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // Prescaler tap masks
   localparam logic [9:0] PRE_MASK_8    = 10'h007;
   localparam logic [9:0] PRE_MASK_64   = 10'h03F;
   localparam logic [9:0] PRE_MASK_256  = 10'h0FF;
   localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

   // One I/O port request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } io_req_s;

endpackage
